// [logic/wdrc_pkg.sv]
package wdrc_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_POR_DRIVE,
    ST_HOLD,
    ST_START
  } wdrc_state_type;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdrc_bus_type;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       xtal_src;
    logic       stop_run;
    logic       halt_run;
    logic [1:0] tap;
  } wdrc_mode_type;

  localparam logic [7:0]  REG_MODE_ADDR = 8'h0f;
  localparam logic [7:0]  REG_RP_ADDR   = 8'hfd;
  localparam logic [3:0]  MODE_BANK     = 4'hf;
  localparam logic [7:0]  MODE_RST      = 8'h00;
  localparam logic [7:0]  RP_RST        = 8'h00;
  localparam logic [2:0]  RSVD_VALUE    = 3'h0;
  localparam logic [7:0]  READ_ZERO     = 8'h00;
  localparam logic [6:0]  WIN_CYCLES    = 7'h3c;
  localparam logic [15:0] HOLD_XCLKS    = 16'h0012;
  localparam logic [15:0] FETCH_DELAY   = 16'h0005;
  localparam logic [11:0] FETCH_ADDR    = 12'h00c;
  localparam logic [2:0]  FLAGS_ZSV     = 3'h0;

endpackage

// [logic/wdrc_divider.sv]
`timescale 1ns/1ps
module wdrc_divider #(
  parameter int DIV = 8
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  output logic      tick_q
);

  logic [15:0] cnt_q;
  wire         wrap = (cnt_q == 16'(DIV - 1));

  if (DIV < 1 || DIV > 65535) begin : g_chk
    $error("wdrc_divider: DIV out of range");
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      tick_q <= wrap;
    end
  end

endmodule // wdrc_divider

// [logic/wdrc_wdog.sv]
`timescale 1ns/1ps
module wdrc_wdog #(
  parameter int CW = 16
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          clear,
  input  wire logic          kick,
  input  wire logic          tick,
  input  wire logic [CW-1:0] limit,
  output logic               en_q,
  output logic               tout_q
);

  logic [CW-1:0] cnt_q;
  wire           hit   = en_q && tick && (cnt_q >= limit - {{(CW-1){1'b0}}, 1'b1});
  wire           en_d  = clear ? 1'b0 : (kick ? 1'b1 : en_q);
  wire           cnt_z = clear || kick || hit;
  wire [CW-1:0]  cnt_d = cnt_z ? '0 :
                         (en_q && tick) ? cnt_q + {{(CW-1){1'b0}}, 1'b1} : cnt_q;

  if (CW < 2 || CW > 32) begin : g_chk
    $error("wdrc_wdog: CW out of range");
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_q   <= 1'b0;
      cnt_q  <= '0;
      tout_q <= 1'b0;
    end else begin
      en_q   <= en_d;
      cnt_q  <= cnt_d;
      tout_q <= hit && !kick && !clear;
    end
  end

endmodule // wdrc_wdog

// [logic/wdrc_top.sv]
// Overview of operation
// - Reset comes from power-on, watchdog time-out, or the low external reset pin.
// - On power-on or watchdog reset the block pulls the reset pin low for POR time.
// - Internal reset holds 18 external clocks, or while the external pin stays low.
// - Fetch starts at address 000C, five processor clocks after internal reset ends.
// - Watchdog is a retriggerable one-shot; terminal count forces a full reset.
// - First watchdog instruction enables it; later ones restart the count.
// - Mode bit 4 picks RC or crystal clock for watchdog and power-on counter.
// - The watchdog instruction updates zero, sign and overflow flags.
// - Mode register writes accepted only within 60 clocks after the first instruction.
// - Time-out during stop keeps mode and register pointer but still delays reset.
// - Mode bits 1 and 0 choose the time-out tap.
// - Mode bit 2 runs watchdog in halt, bit 3 runs it in stop.
// - With bits 3 and 4 set, crystal alone clocks watchdog in stop, waking it.
// - Mode bits 7 to 5 are reserved and do nothing.
// - Mode register is write-only at location 0F of bank F.
// - Pointer low nibble selects bank, high nibble selects working register group.
`timescale 1ns/1ps
module wdrc_top #(
  parameter int RC_DIV    = 8,
  parameter int POR_TICKS = 16,
  parameter int TAP0      = 16,
  parameter int TAP1      = 64,
  parameter int TAP2      = 256,
  parameter int TAP3      = 1024
) (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic                   por_in,
  input  wire logic                   reset_pin_i,
  output logic                        reset_pin_o,
  output logic                        reset_pin_oe,
  input  wire logic                   crystal_input_one,
  input  wire logic                   halt_mode,
  input  wire logic                   stop_mode,
  input  wire logic                   stop_recover,
  input  wire logic                   instr_exec,
  input  wire logic                   wdt_exec,
  input  wire wdrc_pkg::wdrc_bus_type reg_bus,
  output logic [7:0]                  reg_rdata_q,
  output logic [3:0]                  working_group_q,
  output wdrc_pkg::wdrc_mode_type     watchdog_mode_reg,
  output logic                        int_reset_q,
  output logic                        preserve_regs_q,
  output logic                        fetch_start_q,
  output logic [11:0]                 fetch_addr_q,
  output logic                        flag_wr_q,
  output logic [2:0]                  flag_zsv_q,
  output logic                        watchdog_enabled
);

  localparam int CW = 16;

  if (POR_TICKS < 1 || POR_TICKS >= 2**CW || TAP0 < 1 || TAP1 < 1 || TAP2 < 1 ||
      TAP3 < 1 || TAP0 >= 2**CW || TAP1 >= 2**CW || TAP2 >= 2**CW || TAP3 >= 2**CW)
  begin : g_chk
    $error("wdrc_top: count parameter out of range");
  end

  function automatic logic [CW-1:0] tap_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    tap_limit = CW'(TAP0);
      2'h1:    tap_limit = CW'(TAP1);
      2'h2:    tap_limit = CW'(TAP2);
      default: tap_limit = CW'(TAP3);
    endcase
  endfunction

  logic                     rst_s1_q;
  logic                     rst_n;
  logic                     xtal_prev_q;
  logic                     rc_tick;
  logic                     wd_tout;
  logic                     armed_q;
  logic [6:0]               win_q;
  logic [7:0]               rp_q;
  logic [CW-1:0]            cnt_q;
  wdrc_pkg::wdrc_state_type st_q;
  wdrc_pkg::wdrc_state_type st_d;
  wdrc_pkg::wdrc_mode_type  mode_q;
  wdrc_pkg::wdrc_mode_type  mode_d;

  // Reset release through two flip-flops.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Clock sources and watchdog gating.
  wire xtal_tick = crystal_input_one && !xtal_prev_q;
  wire src_tick  = mode_q.xtal_src ? xtal_tick : rc_tick;
  wire stop_tick = mode_q.stop_run && src_tick;
  wire halt_tick = mode_q.halt_run && src_tick;
  wire wd_tick   = stop_mode ? stop_tick : (halt_mode ? halt_tick : src_tick);

  wdrc_divider #(
    .DIV (RC_DIV)
  ) u_rc (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .tick_q (rc_tick)
  );

  wdrc_wdog #(
    .CW (CW)
  ) u_wdog (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clear  (int_reset_q),
    .kick   (wdt_exec && !int_reset_q),
    .tick   (wd_tick),
    .limit  (tap_limit(mode_q.tap)),
    .en_q   (watchdog_enabled),
    .tout_q (wd_tout)
  );

  // Reset causes.
  wire ext_low    = !reset_pin_i && !reset_pin_oe;
  wire wd_stop    = wd_tout && stop_mode;
  wire full_cause = por_in || wd_tout;
  wire ext_cause  = ext_low && (st_q == wdrc_pkg::ST_RUN || st_q == wdrc_pkg::ST_START);
  wire cause      = full_cause || ext_cause;
  wire wipe_regs  = por_in || (wd_tout && !stop_mode) || ext_cause;

  // Sequencer.
  wire por_done   = src_tick && (cnt_q >= CW'(POR_TICKS - 1));
  wire hold_done  = (cnt_q >= wdrc_pkg::HOLD_XCLKS) && !ext_low;
  wire fetch_done = (cnt_q >= wdrc_pkg::FETCH_DELAY - 16'h0001);

  always_comb begin
    st_d = st_q;
    case (st_q)
      wdrc_pkg::ST_RUN:       st_d = st_q;
      wdrc_pkg::ST_POR_DRIVE: st_d = por_done ? wdrc_pkg::ST_HOLD : st_q;
      wdrc_pkg::ST_HOLD:      st_d = hold_done ? wdrc_pkg::ST_START : st_q;
      wdrc_pkg::ST_START:     st_d = fetch_done ? wdrc_pkg::ST_RUN : st_q;
      default:                st_d = wdrc_pkg::ST_RUN;
    endcase
    if (full_cause) begin
      st_d = wdrc_pkg::ST_POR_DRIVE;
    end else if (ext_cause) begin
      st_d = wdrc_pkg::ST_HOLD;
    end
  end

  wire           st_chg  = (st_d != st_q);
  wire           cnt_inc = (st_q == wdrc_pkg::ST_POR_DRIVE) ? src_tick :
                           (st_q == wdrc_pkg::ST_HOLD) ? xtal_tick : 1'b1;
  wire           cnt_sat = (cnt_q == {CW{1'b1}});
  wire [CW-1:0]  cnt_d   = (st_chg || cause) ? '0 :
                           (cnt_inc && !cnt_sat) ? cnt_q + 16'h0001 : cnt_q;
  wire           rst_act = (st_d == wdrc_pkg::ST_POR_DRIVE) || (st_d == wdrc_pkg::ST_HOLD);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= wdrc_pkg::ST_POR_DRIVE;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // Reset pin, internal reset and start of execution.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reset_pin_o   <= 1'b0;
      reset_pin_oe  <= 1'b1;
      int_reset_q   <= 1'b1;
      fetch_start_q <= 1'b0;
      fetch_addr_q  <= wdrc_pkg::FETCH_ADDR;
      xtal_prev_q   <= 1'b0;
    end else begin
      reset_pin_o   <= 1'b0;
      reset_pin_oe  <= (st_d == wdrc_pkg::ST_POR_DRIVE);
      int_reset_q   <= rst_act;
      fetch_start_q <= (st_q == wdrc_pkg::ST_START) && fetch_done && !cause;
      fetch_addr_q  <= wdrc_pkg::FETCH_ADDR;
      xtal_prev_q   <= crystal_input_one;
    end
  end

  // Stop-mode watchdog reset leaves configuration alone.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      preserve_regs_q <= 1'b0;
    end else if (wd_stop) begin
      preserve_regs_q <= 1'b1;
    end else if (wipe_regs) begin
      preserve_regs_q <= 1'b0;
    end
  end

  // Write window after the first instruction.
  wire win_open  = (win_q != 7'h00);
  wire win_start = armed_q && instr_exec && !int_reset_q;
  wire arm_set   = fetch_start_q || stop_recover;
  wire [6:0] win_d = cause ? 7'h00 :
                     win_start ? wdrc_pkg::WIN_CYCLES :
                     win_open ? win_q - 7'h01 : win_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
      win_q   <= 7'h00;
    end else begin
      armed_q <= !cause && (arm_set || (armed_q && !win_start));
      win_q   <= win_d;
    end
  end

  // Register decode.
  wire bank_f   = (rp_q[3:0] == wdrc_pkg::MODE_BANK);
  wire mode_hit = reg_bus.wr && (reg_bus.addr == wdrc_pkg::REG_MODE_ADDR) && bank_f;
  wire mode_wr  = mode_hit && win_open && !int_reset_q;
  wire rp_wr    = reg_bus.wr && (reg_bus.addr == wdrc_pkg::REG_RP_ADDR) && !int_reset_q;
  wire rp_rd    = reg_bus.rd && (reg_bus.addr == wdrc_pkg::REG_RP_ADDR);

  always_comb begin
    mode_d = mode_q;
    if (wipe_regs) begin
      mode_d = wdrc_pkg::MODE_RST;
    end else if (mode_wr) begin
      mode_d      = reg_bus.wdata;
      mode_d.rsvd = wdrc_pkg::RSVD_VALUE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= wdrc_pkg::MODE_RST;
      rp_q   <= wdrc_pkg::RP_RST;
    end else begin
      mode_q <= mode_d;
      rp_q   <= wipe_regs ? wdrc_pkg::RP_RST : (rp_wr ? reg_bus.wdata : rp_q);
    end
  end

  // Reads and flag updates; the mode register never reads back.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q     <= wdrc_pkg::READ_ZERO;
      working_group_q <= 4'h0;
      flag_wr_q       <= 1'b0;
      flag_zsv_q      <= wdrc_pkg::FLAGS_ZSV;
      watchdog_mode_reg <= wdrc_pkg::MODE_RST;
    end else begin
      reg_rdata_q     <= rp_rd ? rp_q : wdrc_pkg::READ_ZERO;
      working_group_q <= rp_d_group(rp_wr, reg_bus.wdata, wipe_regs, rp_q);
      flag_wr_q       <= wdt_exec && !int_reset_q;
      flag_zsv_q      <= wdrc_pkg::FLAGS_ZSV;
      watchdog_mode_reg <= mode_d;
    end
  end

  function automatic logic [3:0] rp_d_group(input logic wr, input logic [7:0] wd,
                                            input logic wipe, input logic [7:0] cur);
    if (wipe) begin
      rp_d_group = wdrc_pkg::RP_RST[7:4];
    end else if (wr) begin
      rp_d_group = wd[7:4];
    end else begin
      rp_d_group = cur[7:4];
    end
  endfunction

endmodule // wdrc_top

// [tb/wdrc_asserts.sv]
`timescale 1ns/1ps
module wdrc_asserts (
  input wire logic                    mclk,
  input wire logic                    nrst,
  input wire logic                    por_in,
  input wire logic                    reset_pin_i,
  input wire logic                    reset_pin_o,
  input wire logic                    reset_pin_oe,
  input wire logic                    crystal_input_one,
  input wire logic                    wdt_exec,
  input wire wdrc_pkg::wdrc_bus_type  reg_bus,
  input wire logic [7:0]              reg_rdata_q,
  input wire logic [3:0]              working_group_q,
  input wire wdrc_pkg::wdrc_mode_type watchdog_mode_reg,
  input wire logic                    int_reset_q,
  input wire logic                    fetch_start_q,
  input wire logic [11:0]             fetch_addr_q,
  input wire logic                    flag_wr_q,
  input wire logic [2:0]              flag_zsv_q
);
  logic       xtal_q;
  logic [7:0] xcnt_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Counts crystal rising edges while the internal reset is held without pin drive.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      xtal_q <= 1'b0;
      xcnt_q <= 8'h00;
    end else begin
      xtal_q <= crystal_input_one;
      if (!int_reset_q || reset_pin_oe) xcnt_q <= 8'h00;
      else if (crystal_input_one && !xtal_q && xcnt_q != 8'hff) xcnt_q <= xcnt_q + 8'h01;
    end
  end
  sequence s_fetch_go;
    ##[5:10] fetch_start_q;
  endsequence
  a_pin_drive_low: assert property (reset_pin_o == 1'b0)
    else $error("reset pin driven high");
  a_por_entry: assert property (por_in |-> ##[1:4] (reset_pin_oe && int_reset_q))
    else $error("power-on cause missed");
  a_ext_entry: assert property (!reset_pin_i && !reset_pin_oe |-> ##[0:1] int_reset_q)
    else $error("pin reset missed");
  a_hold_ext: assert property (int_reset_q && !reset_pin_oe && !reset_pin_i |=> int_reset_q)
    else $error("reset released while pin low");
  a_hold_min: assert property ($fell(int_reset_q) |-> xcnt_q >= 8'h12)
    else $error("reset held too short");
  a_fetch_start: assert property ($fell(int_reset_q) |-> s_fetch_go)
    else $error("fetch start late");
  a_fetch_addr: assert property (fetch_start_q |-> fetch_addr_q == 12'h00c && !int_reset_q)
    else $error("fetch address wrong");
  a_flag_write: assert property (wdt_exec && !int_reset_q |=> flag_wr_q && flag_zsv_q == 3'h0)
    else $error("flags not written");
  a_mode_rd_zero: assert property (reg_bus.rd && reg_bus.addr == 8'h0f |=> reg_rdata_q == 8'h00)
    else $error("mode register readable");
  a_rsvd_zero: assert property (watchdog_mode_reg.rsvd == 3'h0)
    else $error("reserved bits set");
  a_group_write: assert property (reg_bus.wr && reg_bus.addr == 8'hfd && !int_reset_q
    |=> working_group_q == $past(reg_bus.wdata[7:4])) else $error("group not updated");
  a_mode_cause: assert property (!$stable(watchdog_mode_reg) |-> int_reset_q || $past(int_reset_q)
    || ($past(reg_bus.wr) && $past(reg_bus.addr) == 8'h0f)) else $error("mode changed alone");
endmodule // wdrc_asserts

bind wdrc_top wdrc_asserts u_chk (.mclk, .nrst, .por_in, .reset_pin_i, .reset_pin_o,
  .reset_pin_oe, .crystal_input_one, .wdt_exec, .reg_bus, .reg_rdata_q, .working_group_q,
  .watchdog_mode_reg, .int_reset_q, .fetch_start_q, .fetch_addr_q, .flag_wr_q, .flag_zsv_q);

// [tb/wdrc_core_model.sv]
`timescale 1ns/1ps
module wdrc_core_model (
  input  wire logic mclk,
  input  wire logic int_reset_q,
  input  wire logic fetch_start_q,
  input  wire logic reset_pin_oe,
  input  wire logic kick_req,
  input  wire logic ext_low,
  output logic      instr_exec,
  output logic      wdt_exec,
  output logic      reset_pin_i,
  output logic      crystal_input_one
);
  logic       run_q;
  logic [1:0] xdiv_q;
  initial begin
    run_q = 1'b0;
    xdiv_q = 2'h0;
    instr_exec = 1'b0;
    crystal_input_one = 1'b0;
  end
  // The core runs one instruction a cycle from the fetch start until a reset.
  always @(posedge mclk) begin
    if (int_reset_q) run_q <= 1'b0;
    else if (fetch_start_q) run_q <= 1'b1;
  end
  always @(negedge mclk) begin
    instr_exec <= run_q;
    xdiv_q <= (xdiv_q == 2'h2) ? 2'h0 : xdiv_q + 2'h1;
    if (xdiv_q == 2'h2) crystal_input_one <= ~crystal_input_one;
  end
  assign wdt_exec = kick_req && run_q;
  assign reset_pin_i = !(reset_pin_oe || ext_low);
endmodule // wdrc_core_model

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  localparam int RC_DIV = 2;
  localparam int TAP1   = 8;
  logic                    mclk, nrst, por_in, kick_req, ext_low, xp;
  logic                    halt_mode, stop_mode, stop_recover;
  logic                    reset_pin_i, reset_pin_o, reset_pin_oe, crystal_input_one;
  logic                    instr_exec, wdt_exec, int_reset_q, preserve_regs_q;
  logic                    fetch_start_q, flag_wr_q, watchdog_enabled;
  logic [7:0]              reg_rdata_q;
  logic [3:0]              working_group_q;
  logic [11:0]             fetch_addr_q;
  logic [2:0]              flag_zsv_q;
  wdrc_pkg::wdrc_bus_type  reg_bus;
  wdrc_pkg::wdrc_mode_type watchdog_mode_reg;
  int                      n_fail, checks_done, xe, n, x0;

  wdrc_top #(.RC_DIV(RC_DIV), .POR_TICKS(4), .TAP0(4), .TAP1(TAP1), .TAP2(8), .TAP3(16)) i_dut (
    .mclk, .nrst, .por_in, .reset_pin_i, .reset_pin_o, .reset_pin_oe, .crystal_input_one,
    .halt_mode, .stop_mode, .stop_recover, .instr_exec, .wdt_exec,
    .reg_bus, .reg_rdata_q, .working_group_q, .watchdog_mode_reg, .int_reset_q,
    .preserve_regs_q, .fetch_start_q, .fetch_addr_q, .flag_wr_q, .flag_zsv_q,
    .watchdog_enabled);
  wdrc_core_model u_core (.mclk, .int_reset_q, .fetch_start_q, .reset_pin_oe, .kick_req,
    .ext_low, .instr_exec, .wdt_exec, .reset_pin_i, .crystal_input_one);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    xp <= crystal_input_one;
    if (crystal_input_one && !xp) xe <= xe + 1;
  end

  task automatic print_verdict();
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic sel(input int k);
    case (k)
      0: return fetch_start_q;
      1: return int_reset_q;
      default: return !int_reset_q;
    endcase
  endfunction
  task automatic wt(input int k, input int lim);
    n = 0;
    while (sel(k) !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > lim) begin
        n_fail++;
        print_verdict();
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_bus = {1'b0, 1'b1, a, d};
    @(negedge mclk);
    reg_bus = '0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_bus = {1'b1, 1'b0, a, 8'h00};
    @(negedge mclk);
    reg_bus = '0;
    chk({8'h00, reg_rdata_q}, {8'h00, e});
  endtask
  task automatic kick();
    @(negedge mclk);
    kick_req = 1'b1;
    @(negedge mclk);
    kick_req = 1'b0;
  endtask

  initial begin
    nrst = 1'b0;
    por_in = 1'b0;
    kick_req = 1'b0;
    ext_low = 1'b0;
    halt_mode = 1'b0;
    stop_mode = 1'b0;
    stop_recover = 1'b0;
    reg_bus = '0;
    n_fail = 0;
    checks_done = 0;
    xe = 0;
    xp = 1'b0;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    chk(16'(reset_pin_oe), 16'h1);
    wt(0, 2000);
    chk(16'(fetch_addr_q), 16'h00c);
    wr(8'hfd, 8'h30);
    wr(8'h0f, 8'he5);
    chk({8'h00, watchdog_mode_reg}, 16'h00);
    wr(8'hfd, 8'h3f);
    chk(16'(working_group_q), 16'h3);
    wr(8'h0f, 8'he5);
    chk({8'h00, watchdog_mode_reg}, 16'h05);
    rd(8'h0f, 8'h00);
    rd(8'hfd, 8'h3f);
    repeat (60) @(negedge mclk);
    wr(8'h0f, 8'h02);
    chk({8'h00, watchdog_mode_reg}, 16'h05);
    kick();
    chk(16'(flag_wr_q), 16'h1);
    chk(16'(flag_zsv_q), 16'h0);
    repeat (8) begin
      kick();
      repeat (4) @(negedge mclk);
    end
    chk(16'(watchdog_enabled), 16'h1);
    chk(16'(int_reset_q), 16'h0);
    kick();
    wt(1, 300);
    chk(16'(n >= TAP1 * RC_DIV - 4 && n <= TAP1 * RC_DIV + 6), 16'h1);
    chk(16'(reset_pin_oe), 16'h1);
    wt(0, 2000);
    chk({8'h00, watchdog_mode_reg}, 16'h00);
    chk(16'(watchdog_enabled), 16'h0);
    x0 = xe;
    ext_low = 1'b1;
    repeat (40) @(negedge mclk);
    chk(16'(int_reset_q), 16'h1);
    ext_low = 1'b0;
    wt(2, 2000);
    chk(16'(xe - x0 >= 18), 16'h1);
    wt(0, 100);
    ext_low = 1'b1;
    repeat (150) @(negedge mclk);
    chk(16'(int_reset_q), 16'h1);
    ext_low = 1'b0;
    wt(2, 2000);
    chk(16'(n <= 2), 16'h1);
    wt(0, 100);
    por_in = 1'b1;
    @(negedge mclk);
    por_in = 1'b0;
    wt(1, 4);
    chk(16'(reset_pin_oe), 16'h1);
    wt(0, 2000);
    chk(16'(fetch_addr_q), 16'h00c);
    halt_mode = 1'b1;
    kick();
    repeat (40) @(negedge mclk);
    chk(16'(int_reset_q), 16'h0);
    halt_mode = 1'b0;
    wt(1, 40);
    chk(16'(reset_pin_oe), 16'h1);
    wt(0, 2000);
    wr(8'hfd, 8'h0f);
    wr(8'h0f, 8'h08);
    chk({8'h00, watchdog_mode_reg}, 16'h08);
    kick();
    stop_mode = 1'b1;
    wt(1, 100);
    chk(16'(preserve_regs_q), 16'h1);
    stop_mode = 1'b0;
    wt(0, 2000);
    chk({8'h00, watchdog_mode_reg}, 16'h08);
    print_verdict();
  end
endmodule // testbench
